// >>> rtl/sfb_pkg.sv
// Constants and carrier types for the safe fieldbus select/acknowledge block.
// Assumes a single 200 MHz APB clock domain and byte-wide telegram streams.
package sfb_pkg;

    localparam int          TEL_BYTES      = 6;
    localparam logic [2:0]  IDX_CTRL_LO    = 3'h0;
    localparam logic [2:0]  IDX_CTRL_HI    = 3'h1;
    localparam logic [2:0]  IDX_PROTO      = 3'h2;
    localparam logic [2:0]  IDX_CONS       = 3'h3;
    localparam logic [2:0]  IDX_CRC_HI     = 3'h4;
    localparam logic [2:0]  IDX_CRC_LO     = 3'h5;

    localparam logic [7:0]  OFF_CTRL_WORD  = 8'h00;
    localparam logic [7:0]  OFF_STAT_WORD  = 8'h04;
    localparam logic [7:0]  OFF_DEST_ADDR  = 8'h08;
    localparam logic [7:0]  OFF_SRC_ADDR   = 8'h0c;
    localparam logic [7:0]  OFF_LINK_STAT  = 8'h10;

    localparam logic [15:0] RST_CTRL_WORD  = 16'h0000;
    localparam logic [15:0] RST_STAT_WORD  = 16'h0000;
    localparam logic [15:0] RST_DEST_ADDR  = 16'h0001;
    localparam logic [15:0] RST_SRC_ADDR   = 16'h0001;
    localparam logic [15:0] CRC_POLY       = 16'h1021;

    localparam int          CB_MODE_SEL    = 0;
    localparam int          CB_ESTOP       = 1;
    localparam int          CB_ENABLING    = 2;
    localparam int          CB_SWITCH_ONE  = 3;
    localparam int          CB_SWITCH_TWO  = 4;
    localparam int          CB_SAFE_OUT    = 7;

    typedef struct packed {
        logic [3:0] safe_input;
        logic       safety_error;
        logic       safe_stop_one;
        logic       safety_established;
    } sfb_status_in_t;

    typedef struct packed {
        logic mode_selector_req;
        logic emergency_stop_switch_req;
        logic enabling_control_req;
        logic safety_switch_one_req;
        logic safety_switch_two_req;
        logic safe_output_cmd;
        logic home_switch_req;
    } sfb_select_t;

endpackage : sfb_pkg

// >>> rtl/sfb_select_ack.sv
// Safe fieldbus selection and acknowledgment for both safety channels.
// Assumes telegram bytes arrive on a byte stream synchronous to pclk and
// that the reply stream sink may stall; registers sit on a zero-wait APB.

// Overview of operation
// (RQ1) Accept 16-bit control word from master.
// (RQ2) Control byte 1 low, byte 2 high.
// (RQ3) Bit 0 drives mode selector request.
// (RQ4) Bit 1 drives emergency-stop switch request.
// (RQ5) Bit 2 drives enabling-control request.
// (RQ6) Bits 3, 4 drive safety-switch requests.
// (RQ7) Bit 7 commands safe output, 0 inactive.
// (RQ8) Received control bits readable in register.
// (RQ9) Send 16-bit status word to master.
// (RQ10) Status byte 1 low, byte 2 high.
// (RQ11) Ignore upper received byte, send reserved upper.
// (RQ12) Status bit 0 shows established safety.
// (RQ13) Status bit 1 shows safe stop active.
// (RQ14) Status bit 2 shows safety error.
// (RQ15) Status bits 4 to 7 show inputs.
// (RQ16) Acknowledged status word readable in register.
// (RQ17) Command telegram: data, control, number, CRC2.
// (RQ18) Reply telegram: data, status, number, CRC2.
// (RQ19) No test-pulse check on received bits.
// (RQ20) Only home switch comes from local input.
// (RQ21) Configurable destination and source addresses held.
// (RQ22) Apply bits only after CRC, number pass.
// (RQ23) Bits 5, 6, upper bytes, status 3 zero.
module sfb_select_ack (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    rx_valid,
    input  wire logic                    rx_first,
    input  wire logic [7:0]              rx_data,
    output logic                         rx_ready,
    output logic                         tx_valid,
    output logic      [7:0]              tx_data,
    input  wire logic                    tx_ready,
    input  wire sfb_pkg::sfb_status_in_t status_in,
    input  wire logic                    home_switch_in,
    output sfb_pkg::sfb_select_t         select_out
);

    function automatic logic [15:0] crc_byte(input logic [15:0] crc,
                                             input logic [7:0]  d);
        logic [15:0] c;
        c = crc ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ((c << 1) ^ sfb_pkg::CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : crc_byte

    // The seed binds both addresses into the check, so a telegram meant for
    // another axis or another controller fails even with intact data.
    function automatic logic [15:0] crc_tel(input logic [15:0] seed,
                                            input logic [7:0]  b0,
                                            input logic [7:0]  b1,
                                            input logic [7:0]  b2,
                                            input logic [7:0]  b3);
        return crc_byte(crc_byte(crc_byte(crc_byte(seed, b0), b1), b2), b3);
    endfunction : crc_tel

    logic [15:0] ctrl_word;
    logic [15:0] stat_word;
    logic [15:0] dest_addr;
    logic [15:0] src_addr;
    logic [7:0]  rx_buf [0:4];
    logic [7:0]  tx_buf [0:5];
    logic [2:0]  rx_idx;
    logic [2:0]  tx_idx;
    logic        tx_busy;
    logic        synced;
    logic [7:0]  next_cons;
    logic        last_fault;
    logic [7:0]  fault_count;
    logic [7:0]  good_count;

    wire         apb_access = psel & penable;
    wire         apb_wr     = apb_access & pwrite;
    wire         hit_ctrl   = paddr == sfb_pkg::OFF_CTRL_WORD;
    wire         hit_stat   = paddr == sfb_pkg::OFF_STAT_WORD;
    wire         hit_dest   = paddr == sfb_pkg::OFF_DEST_ADDR;
    wire         hit_src    = paddr == sfb_pkg::OFF_SRC_ADDR;
    wire         hit_link   = paddr == sfb_pkg::OFF_LINK_STAT;
    wire         hit_any    = hit_ctrl | hit_stat | hit_dest | hit_src
                              | hit_link;
    wire         ro_write   = pwrite & (hit_ctrl | hit_stat | hit_link);
    wire [15:0]  crc_seed   = dest_addr ^ src_addr;  // [RQ21]

    wire         rx_take    = rx_valid & rx_ready;
    wire         tel_start  = rx_take & rx_first;
    wire         tel_end    = rx_take & ~rx_first
                              & (rx_idx == sfb_pkg::IDX_CRC_LO);
    wire [15:0]  rx_crc_got = {rx_buf[4], rx_data};
    wire [15:0]  rx_crc_exp = crc_tel(crc_seed, rx_buf[0], rx_buf[1],
                                      rx_buf[2], rx_buf[3]);
    wire         crc_ok     = rx_crc_got == rx_crc_exp;  // [RQ17]
    wire         cons_ok    = ~synced | (rx_buf[3] == next_cons);
    wire         tel_ok     = tel_end & crc_ok & cons_ok;  // [RQ22]

    // Upper control byte and bits 5, 6 are stored for display but never
    // reach a selection output.
    wire [15:0]  rx_word    = {rx_buf[1], rx_buf[0]};  // [RQ1] [RQ2]

    // Status bit 3 and the whole upper byte are sent as zero.
    wire [15:0]  new_stat   = {8'h00, status_in.safe_input, 1'b0,
                               status_in.safety_error,
                               status_in.safe_stop_one,
                               status_in.safety_established};  // [RQ12] [RQ13] [RQ14] [RQ15] [RQ11] [RQ23]
    wire [7:0]   rep_proto  = {7'h00, ~tel_ok};
    wire [15:0]  rep_crc    = crc_tel(crc_seed, new_stat[7:0],
                                      new_stat[15:8], rep_proto,
                                      rx_buf[3]);  // [RQ18]

    // A new command is refused while the previous reply still drains, which
    // stalls the master instead of dropping an acknowledgment.
    assign rx_ready = ~tx_busy;
    assign tx_valid = tx_busy;
    assign tx_data  = tx_buf[tx_idx];
    assign pready   = 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_idx <= 3'h0;
        end else if (tel_start) begin
            rx_idx <= 3'h1;
        end else if (rx_take && rx_idx != 3'h0 && !tel_end) begin
            rx_idx <= rx_idx + 3'h1;
        end else if (tel_end) begin
            rx_idx <= 3'h0;
        end
    end

    // A byte without the start mark outside a telegram is dropped.
    always_ff @(posedge pclk) begin
        if (tel_start) begin
            rx_buf[0] <= rx_data;
        end else if (rx_take && rx_idx != 3'h0 && !tel_end) begin
            rx_buf[rx_idx] <= rx_data;
        end
    end

    // Bits go straight from a checked telegram to the outputs; there is no
    // test-pulse comparison because the CRC already covers both channels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_word <= sfb_pkg::RST_CTRL_WORD;
        end else if (tel_ok) begin
            ctrl_word <= rx_word;  // [RQ8] [RQ19]
        end else if (tel_end) begin
            ctrl_word <= sfb_pkg::RST_CTRL_WORD;  // [RQ22]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            synced    <= 1'b0;
            next_cons <= 8'h00;
        end else if (tel_ok) begin
            synced    <= 1'b1;
            next_cons <= rx_buf[3] + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_fault  <= 1'b0;
            fault_count <= 8'h00;
            good_count  <= 8'h00;
        end else if (tel_end) begin
            last_fault  <= ~tel_ok;
            fault_count <= fault_count + {7'h00, ~tel_ok};
            good_count  <= good_count + {7'h00, tel_ok};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_word <= sfb_pkg::RST_STAT_WORD;
        end else if (tel_end) begin
            stat_word <= new_stat;  // [RQ16] [RQ9]
        end
    end

    always_ff @(posedge pclk) begin
        if (tel_end) begin
            tx_buf[0] <= new_stat[7:0];  // [RQ10]
            tx_buf[1] <= new_stat[15:8];
            tx_buf[2] <= rep_proto;
            tx_buf[3] <= rx_buf[3];
            tx_buf[4] <= rep_crc[15:8];
            tx_buf[5] <= rep_crc[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_busy <= 1'b0;
            tx_idx  <= 3'h0;
        end else if (tel_end) begin
            tx_busy <= 1'b1;
            tx_idx  <= 3'h0;
        end else if (tx_busy && tx_ready) begin
            tx_busy <= tx_idx != sfb_pkg::IDX_CRC_LO;
            tx_idx  <= (tx_idx == sfb_pkg::IDX_CRC_LO) ? 3'h0
                                                        : tx_idx + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dest_addr <= sfb_pkg::RST_DEST_ADDR;
            src_addr  <= sfb_pkg::RST_SRC_ADDR;
        end else if (apb_wr && hit_dest) begin
            dest_addr <= pwdata[15:0];  // [RQ21]
        end else if (apb_wr && hit_src) begin
            src_addr  <= pwdata[15:0];  // [RQ21]
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (apb_access && !pwrite) begin
            case (1'b1)
                hit_ctrl: prdata = {16'h0000, ctrl_word};  // [RQ8]
                hit_stat: prdata = {16'h0000, stat_word};  // [RQ16]
                hit_dest: prdata = {16'h0000, dest_addr};
                hit_src:  prdata = {16'h0000, src_addr};
                hit_link: prdata = {good_count, fault_count, 14'h0000,
                                    last_fault, synced};
                default:  prdata = 32'h0000_0000;
            endcase
        end
    end

    assign pslverr = apb_access & (~hit_any | ro_write);

    // Selection bits come only from the accepted word; 0 is the deselected,
    // safe level. The home switch is the one local input still honoured.
    assign select_out.mode_selector_req =
        ctrl_word[sfb_pkg::CB_MODE_SEL];  // [RQ3]
    assign select_out.emergency_stop_switch_req =
        ctrl_word[sfb_pkg::CB_ESTOP];  // [RQ4]
    assign select_out.enabling_control_req =
        ctrl_word[sfb_pkg::CB_ENABLING];  // [RQ5]
    assign select_out.safety_switch_one_req =
        ctrl_word[sfb_pkg::CB_SWITCH_ONE];  // [RQ6]
    assign select_out.safety_switch_two_req =
        ctrl_word[sfb_pkg::CB_SWITCH_TWO];  // [RQ6]
    assign select_out.safe_output_cmd =
        ctrl_word[sfb_pkg::CB_SAFE_OUT];  // [RQ7] [RQ23]
    assign select_out.home_switch_req = home_switch_in;  // [RQ20]

endmodule : sfb_select_ack

// >>> bench/sfb_select_ack_checker.sv
// Port-level assertions for the safe fieldbus select/acknowledge block.
// Assumes one pclk domain with presetn as the asynchronous reset.
module sfb_select_ack_checker (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          prdata,
    input wire logic                 pslverr,
    input wire logic                 rx_valid,
    input wire logic                 rx_ready,
    input wire logic                 tx_valid,
    input wire logic [7:0]           tx_data,
    input wire logic                 tx_ready,
    input wire logic                 home_switch_in,
    input wire sfb_pkg::sfb_select_t select_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] tx_idx;
    wire        acc = psel && penable;
    wire        take = rx_valid && rx_ready;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Reply byte position, so each byte of a reply can be judged alone.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn || !tx_valid)
            tx_idx <= 3'h0;
        else if (tx_ready)
            tx_idx <= tx_idx + 3'h1;
    end
    property p_home; select_out.home_switch_req == home_switch_in; endproperty
    property p_block; tx_valid |-> !rx_ready; endproperty
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    property p_sel; !take |=> $stable(select_out[6:1]); endproperty
    property p_start; $rose(tx_valid) |-> $past(take); endproperty
    property p_len; tx_valid && tx_ready && tx_idx == 3'h5 |=> !tx_valid;
    endproperty
    property p_hi; tx_valid && tx_idx == 3'h1 |-> tx_data == 8'h00; endproperty
    property p_bit3; tx_valid && tx_idx == 3'h0 |-> !tx_data[3]; endproperty
    property p_ro;
        acc && pwrite && paddr == sfb_pkg::OFF_CTRL_WORD |-> pslverr;
    endproperty
    property p_up;
        acc && !pwrite && paddr == sfb_pkg::OFF_STAT_WORD |-> prdata[31:8] == 0;
    endproperty
    a_home: assert property (p_home) else $error("home path wrong");
    a_block: assert property (p_block) else $error("rx open in reply");
    a_hold: assert property (p_hold) else $error("reply byte moved");
    a_sel: assert property (p_sel) else $error("select moved");
    a_start: assert property (p_start) else $error("reply unasked");
    a_len: assert property (p_len) else $error("reply length");
    a_hi: assert property (p_hi) else $error("status hi not 0");
    a_bit3: assert property (p_bit3) else $error("status bit3 set");
    a_ro: assert property (p_ro) else $error("RO write taken");
    a_up: assert property (p_up) else $error("status upper set");
    c_stall: cover property (tx_valid && !tx_ready);
    c_rej: cover property (tx_valid && tx_idx == 3'h2 && tx_data[0]);
    c_err: cover property (acc && pslverr);
endmodule : sfb_select_ack_checker

bind sfb_select_ack sfb_select_ack_checker sfb_select_ack_checker_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
    .rx_valid, .rx_ready, .tx_valid, .tx_data, .tx_ready, .home_switch_in,
    .select_out
);

// >>> bench/sfb_plc_model.sv
// Safety controller model: sends command telegrams, collects replies.
// Assumes the block's byte streams on pclk; slow makes it stall replies.
module sfb_plc_model (
    input  wire logic        pclk,
    input  wire logic        slow,
    output logic             rx_valid,
    output logic             rx_first,
    output logic [7:0]       rx_data,
    input  wire logic        rx_ready,
    input  wire logic        tx_valid,
    input  wire logic [7:0]  tx_data,
    output logic             tx_ready,
    output logic [47:0]      rep
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt = 3'h0;
    initial begin
        rx_valid = 1'b0;
        rx_first = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b1;
    end
    // Replies land byte by byte; stalls every other cycle when slow.
    always @(posedge pclk) begin
        tx_ready <= !slow || !tx_ready;
        if (rx_valid && rx_first)
            cnt <= 3'h0;
        else if (tx_valid && tx_ready) begin
            rep <= {rep[39:0], tx_data};
            cnt <= cnt + 3'h1;
        end
    end
    task automatic send(input logic [47:0] tel);
        for (int i = 0; i < 6; i++) begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_first <= (i == 0);
            rx_data <= tel[47 - 8 * i -: 8];
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_data <= ~tel[7:0];
        for (int t = 0; t < 200 && cnt != 3'h6; t++)
            @(posedge pclk);
    endtask : send
endmodule : sfb_plc_model

// >>> bench/sfb_select_ack_tb.sv
// Self-checking bench for the safe fieldbus select/acknowledge block.
// Assumes the controller model in sfb_plc_model and a zero-wait APB.
module sfb_select_ack_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic rx_valid, rx_first, rx_ready, tx_valid, tx_ready, pready, pslverr;
    logic home_switch_in = 0, slow = 0;
    logic [7:0]  paddr = 0, rx_data, tx_data, cn = 8'hfe;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [47:0] rep;
    logic [15:0] seed = 16'h0000;
    sfb_pkg::sfb_status_in_t status_in = '0;
    sfb_pkg::sfb_select_t    select_out;
    int err_count = 0, compares = 0;
    always #2.5 pclk = ~pclk;
    sfb_select_ack sfb_select_ack_i (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_valid,
        .rx_first, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready,
        .status_in, .home_switch_in, .select_out);
    sfb_plc_model sfb_plc_model_i (.pclk, .slow, .rx_valid, .rx_first,
        .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .rep);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("Compares %0d, errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    function automatic logic [15:0] crc(input logic [15:0] s,
                                        input logic [31:0] d);
        for (int i = 31; i >= 0; i--)
            s = {s[14:0], 1'b0}
                ^ ((s[15] ^ d[i]) ? sfb_pkg::CRC_POLY : 16'h0000);
        return s;
    endfunction : crc
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // One telegram; a rejected one must leave every selection but the home switch safe.
    task automatic run(input logic [15:0] cw, input logic bad, input logic ok);
        logic [31:0] body;
        logic [7:0]  st;
        logic [5:0]  sel;
        body = {cw[7:0], cw[15:8], 8'h00, cn};
        sfb_plc_model_i.send({body, crc(seed, body) ^ {15'h0000, bad}});
        st = {status_in[6:3], 1'b0, status_in[2:0]};
        sel = ok ? {cw[0], cw[1], cw[2], cw[3], cw[4], cw[7]} : 6'h00;
        check(select_out[6:1], sel);
        check(rep[47:32], {st, 8'h00});
        check({rep[24], rep[23:16]}, {!ok, cn});
        check(rep[15:0], crc(seed, rep[47:16]));
        apb(1'b0, sfb_pkg::OFF_CTRL_WORD, 0);
        check(rd[7:0], ok ? cw[7:0] : 8'h00);
        apb(1'b0, sfb_pkg::OFF_STAT_WORD, 0);
        check(rd, st);
        if (ok)
            cn++;
    endtask : run
    task automatic t_regs;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 0);
            check(rd, i / 2);
        end
        check(select_out[6:1], 0);
    endtask : t_regs
    task automatic t_bits;
        for (int i = 0; i < 9; i++) begin
            status_in <= 7'(8'h9b >> i);
            run(16'hff00 | 16'(1 << i), 1'b0, 1'b1);
        end
    endtask : t_bits
    task automatic t_apb;
        apb(1'b1, sfb_pkg::OFF_CTRL_WORD, 1);
        check(er, 1);
        apb(1'b0, 8'h14, 0);
        check({rd[30:0], er}, 1);
        apb(1'b1, sfb_pkg::OFF_DEST_ADDR, 32'h00a5);
        apb(1'b0, sfb_pkg::OFF_DEST_ADDR, 0);
        check(rd, 32'h00a5);
        seed = 16'h00a4;
        slow <= 1'b1;
        run(16'h0099, 1'b0, 1'b1);
        slow <= 1'b0;
    endtask : t_apb
    task automatic t_reject;
        cn = cn + 8'h02;
        run(16'h00ff, 1'b0, 1'b0);
        run(16'h00ff, 1'b1, 1'b0);
        home_switch_in <= 1'b1;
        @(negedge pclk);
        check(select_out.home_switch_req, 1);
    endtask : t_reject
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_bits();
        t_apb();
        t_reject();
        stop_test();
    end
    initial begin
        #100us;
        err_count++;
        stop_test();
    end
endmodule : sfb_select_ack_tb
